//--- src/dwcr_top.sv
/*
 Downstream memory window base registers plus read-only header words 20h-38h.
 Assumes classic Wishbone access; setup words are loaded by software here.
*/
// The Wishbone slave port was chosen for this implementation.
// How it works
// - Low base bits fixed: memory, type, zeros.
// - Bit 3 shows prefetchable, reset zero.
// - Setup word sizes and types base field.
// - Base bit writable only where setup one.
// - Setup bit 31 zero disables window base.
// - Window sizes span 4KB up to 8EB.
// - 32-bit mode translates via translated base.
// - 64-bit mode forwards address unchanged.
// - Upper base sized by upper setup word.
// - Upper setup bit 31 zero disables upper.
// - Subsystem vendor and device identifiers read-only.
// - Dwords 28h and 30h are reserved.
// - Capability pointer reads 80h.
// - Expansion ROM register reads zero.
`timescale 1ns/10ps
module dwcr_top
   import dwcr_pkg::*;
#(
   // Arbitrary identity values
   parameter logic [15:0] SUBSYS_VENDOR = 16'h1234,
   parameter logic [15:0] SUBSYS_DEVICE = 16'h5678
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [63:0] req_addr,
   output logic win_hit,
   output logic [63:0] fwd_addr
);
   typedef struct packed {
      logic [31:0] base;
      logic [31:0] upper;
      logic [31:0] setup_lo;
      logic [31:0] setup_hi;
      logic [31:0] xlat;
      logic [31:0] rdata;
      logic hit;
      logic [63:0] fwd;
   } dwcr_state_t;
   dwcr_state_t st_q, st_d;

   logic acc_wr;
   logic acc_rd;
   logic lo_en;
   logic hi_en;
   logic is64;
   logic [31:0] bmask;
   logic [63:0] win_mask;
   logic comb_hit;
   logic [63:0] comb_fwd;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel, input logic [31:0] wmask);
      logic [31:0] be;
      be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
      return (old & ~be) | (nw & be);
   endfunction : merge

   dwcr_wb_slave u_slv (
      .clock(clock),
      .nrst(nrst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o),
      .acc_wr(acc_wr),
      .acc_rd(acc_rd)
   );

   // ==========================================
   // Window decode
   assign lo_en = st_q.setup_lo[DWCR_ENABLE_BIT];
   assign hi_en = st_q.setup_hi[DWCR_ENABLE_BIT];
   assign is64 = st_q.setup_lo[2:1] == DWCR_TYPE_64;
   // Mask bits 31:12 from setup give 4KB minimum granularity
   assign bmask = st_q.setup_lo & ~DWCR_LOW_RO_MASK;
   // Upper half only decodes in 64-bit mode, giving the large end of range
   assign win_mask = {(is64 && hi_en) ? st_q.setup_hi : 32'h0000_0000, bmask};

   dwcr_xlate u_xl (
      .in_addr(req_addr),
      .base({st_q.upper, st_q.base}),
      .mask(win_mask),
      .is64(is64),
      .xlat_base(st_q.xlat),
      .en(lo_en),
      .hit(comb_hit),
      .out_addr(comb_fwd)
   );

   // ==========================================
   // Register file
   always_comb
   begin
      st_d = st_q;
      st_d.hit = comb_hit;
      st_d.fwd = comb_fwd;
      // Writes land on the edge where the master samples ack
      if (acc_wr && wb_we_i)
      begin
         unique case (wb_adr_i)
            DWCR_OFF_BASE:
               if (lo_en)
                  st_d.base = merge(st_q.base, wb_dat_i, wb_sel_i, bmask);
            DWCR_OFF_UPPER:
               if (hi_en)
                  st_d.upper = merge(st_q.upper, wb_dat_i, wb_sel_i, st_q.setup_hi);
            DWCR_OFF_SETUP_LO:
               st_d.setup_lo = merge(st_q.setup_lo, wb_dat_i, wb_sel_i, 32'hffff_f00e);
            DWCR_OFF_SETUP_HI:
               st_d.setup_hi = merge(st_q.setup_hi, wb_dat_i, wb_sel_i, 32'hffff_ffff);
            DWCR_OFF_XLAT:
               st_d.xlat = merge(st_q.xlat, wb_dat_i, wb_sel_i, 32'hffff_f000);
            default:
               st_d.rdata = st_q.rdata;
         endcase
      end
      // Read data is captured one edge early so it stands with ack
      if (acc_rd)
      begin
         unique case (wb_adr_i)
            // Low bits mirror setup type and prefetch, bit 0 memory
            DWCR_OFF_BASE:
               st_d.rdata = lo_en ? ((st_q.base & bmask) | {28'h0000000,
                  st_q.setup_lo[DWCR_PREF_BIT], st_q.setup_lo[2:1], 1'b0}) : 32'h0000_0000;
            DWCR_OFF_UPPER:
               st_d.rdata = hi_en ? (st_q.upper & st_q.setup_hi) : 32'h0000_0000;
            DWCR_OFF_SUBSYS:
               st_d.rdata = {SUBSYS_DEVICE, SUBSYS_VENDOR};
            DWCR_OFF_CAP:
               st_d.rdata = {24'h000000, DWCR_CAP_PTR};
            DWCR_OFF_ROM:
               st_d.rdata = DWCR_ROM_VALUE;
            DWCR_OFF_SETUP_LO:
               st_d.rdata = st_q.setup_lo;
            DWCR_OFF_SETUP_HI:
               st_d.rdata = st_q.setup_hi;
            DWCR_OFF_XLAT:
               st_d.rdata = st_q.xlat;
            DWCR_OFF_STATUS:
               st_d.rdata = {29'h0000000, st_q.hit, is64, lo_en};
            default:
               st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= '0;
         st_q.setup_lo <= DWCR_SETUP_LO_RST;
         st_q.setup_hi <= DWCR_SETUP_HI_RST;
      end
      else
         st_q <= st_d;
   end

   assign wb_dat_o = st_q.rdata;
   assign win_hit = st_q.hit;
   assign fwd_addr = st_q.fwd;

   // ==========================================
   // Read-back checks
   chk_base_low_ro: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_BASE
      |-> wb_dat_o[0] == 1'b0 && wb_dat_o[11:4] == 8'h00)
      else $error("base low bits wrong");
   chk_type_mirror: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_BASE && $past(lo_en)
      |-> wb_dat_o[2:1] == $past(st_q.setup_lo[2:1]))
      else $error("address type bits wrong");
   chk_pref_bit: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_BASE && $past(lo_en)
      |-> wb_dat_o[3] == $past(st_q.setup_lo[3]))
      else $error("prefetch bit wrong");
   chk_base_read_off: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_BASE && !$past(lo_en)
      |-> wb_dat_o == 32'h0000_0000)
      else $error("disabled base reads nonzero");
   chk_upper_read_off: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_UPPER && !$past(hi_en)
      |-> wb_dat_o == 32'h0000_0000)
      else $error("disabled upper reads nonzero");
   chk_subsys_ro: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_SUBSYS
      |-> wb_dat_o == {SUBSYS_DEVICE, SUBSYS_VENDOR})
      else $error("subsystem identifiers wrong");
   chk_cap_ptr: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_CAP |-> wb_dat_o == 32'h0000_0080)
      else $error("capability pointer wrong");
   chk_rom_zero: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && $past(wb_adr_i) == DWCR_OFF_ROM |-> wb_dat_o == 32'h0000_0000)
      else $error("rom register nonzero");
   chk_rsvd_zero: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && ($past(wb_adr_i) == DWCR_OFF_RSVD_A || $past(wb_adr_i) == DWCR_OFF_RSVD_B)
      |-> wb_dat_o == 32'h0000_0000)
      else $error("reserved nonzero");

   // ==========================================
   // Bus handshake checks
   chk_ack_answer: assert property (@(posedge clock) disable iff (!nrst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   chk_ack_drop: assert property (@(posedge clock) disable iff (!nrst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   chk_no_ack_idle: assert property (@(posedge clock) disable iff (!nrst)
      !$past(wb_stb_i) |-> !wb_ack_o)
      else $error("ack without request");
   // Read data stands until the next access so a slow master still sees it
   chk_dat_hold: assert property (@(posedge clock) disable iff (!nrst)
      !$past(acc_rd) |-> $stable(wb_dat_o))
      else $error("read data moved");

   // ==========================================
   // Write and decode checks
   // Independent decode terms, so the hit checks do not reuse the translator
   logic lo_match;
   logic up_miss;
   assign lo_match = lo_en && !(is64 && hi_en)
      && (((req_addr[31:0] ^ st_q.base) & bmask) == 32'h0000_0000);
   assign up_miss = lo_en && is64 && hi_en
      && (((req_addr[63:32] ^ st_q.upper) & st_q.setup_hi) != 32'h0000_0000);
   // Compared with the previous value, as a shrunken mask may leave stale base bits
   chk_base_masked: assert property (@(posedge clock) disable iff (!nrst)
      ((st_q.base ^ $past(st_q.base)) & ~$past(bmask)) == 32'h0000_0000)
      else $error("base bit outside size changed");
   chk_upper_masked: assert property (@(posedge clock) disable iff (!nrst)
      ((st_q.upper ^ $past(st_q.upper)) & ~$past(st_q.setup_hi)) == 32'h0000_0000)
      else $error("upper bit outside size changed");
   chk_base_write: assert property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i == DWCR_OFF_BASE && lo_en && wb_sel_i == 4'hf
      |=> (st_q.base & $past(bmask)) == ($past(wb_dat_i) & $past(bmask)))
      else $error("base write lost");
   chk_upper_write: assert property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i == DWCR_OFF_UPPER && hi_en && wb_sel_i == 4'hf
      |=> (st_q.upper & $past(st_q.setup_hi)) == ($past(wb_dat_i) & $past(st_q.setup_hi)))
      else $error("upper write lost");
   chk_setup_write: assert property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i == DWCR_OFF_SETUP_LO && wb_sel_i == 4'hf
      |=> st_q.setup_lo == ($past(wb_dat_i) & 32'hffff_f00e))
      else $error("setup write lost");
   chk_xlat_write: assert property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i == DWCR_OFF_XLAT && wb_sel_i == 4'hf
      |=> st_q.xlat == ($past(wb_dat_i) & 32'hffff_f000))
      else $error("translated base write lost");
   chk_ro_no_write: assert property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i >= DWCR_OFF_RSVD_A && wb_adr_i <= DWCR_OFF_ROM
      |=> $stable(st_q.base) && $stable(st_q.upper) && $stable(st_q.setup_lo)
      && $stable(st_q.setup_hi) && $stable(st_q.xlat))
      else $error("read-only write changed state");
   chk_disable_base: assert property (@(posedge clock) disable iff (!nrst)
      !lo_en && !$past(lo_en) |-> $stable(st_q.base))
      else $error("disabled base changed");
   chk_disable_upper: assert property (@(posedge clock) disable iff (!nrst)
      !hi_en && !$past(hi_en) |-> $stable(st_q.upper))
      else $error("disabled upper changed");
   chk_hit_off: assert property (@(posedge clock) disable iff (!nrst)
      !$past(lo_en) |-> !win_hit)
      else $error("disabled window hit");
   chk_hit_32_match: assert property (@(posedge clock) disable iff (!nrst)
      $past(lo_match) |-> win_hit)
      else $error("window match missed");
   chk_hit_upper_miss: assert property (@(posedge clock) disable iff (!nrst)
      $past(up_miss) |-> !win_hit)
      else $error("upper half mismatch hit");
   chk_fwd_64: assert property (@(posedge clock) disable iff (!nrst)
      $past(is64) |-> fwd_addr == $past(req_addr))
      else $error("64-bit address altered");
   chk_fwd_32: assert property (@(posedge clock) disable iff (!nrst)
      !$past(is64) |-> fwd_addr[31:12] == ($past(st_q.xlat[31:12]) & $past(bmask[31:12]) |
      $past(req_addr[31:12]) & ~$past(bmask[31:12])))
      else $error("translation wrong");
   chk_fwd_low: assert property (@(posedge clock) disable iff (!nrst)
      $past(nrst) |-> fwd_addr[11:0] == $past(req_addr[11:0]))
      else $error("page offset altered");

   // ==========================================
   // Coverage
   cov_base_write: cover property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i == DWCR_OFF_BASE && lo_en);
   cov_upper_write: cover property (@(posedge clock) disable iff (!nrst)
      acc_wr && wb_we_i && wb_adr_i == DWCR_OFF_UPPER && hi_en);
   cov_hit_64: cover property (@(posedge clock) disable iff (!nrst) win_hit && is64);
   cov_hit_32: cover property (@(posedge clock) disable iff (!nrst) win_hit && !is64);
   cov_read_off: cover property (@(posedge clock) disable iff (!nrst)
      wb_ack_o && !lo_en && $past(wb_adr_i) == DWCR_OFF_BASE);
endmodule : dwcr_top

//--- src/dwcr_pkg.sv
/*
 Constants for the downstream window configuration register block.
 Assumes a 32-bit classic Wishbone slave port with byte addressing.
*/
package dwcr_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] DWCR_OFF_BASE = 8'h20;
   localparam logic [7:0] DWCR_OFF_UPPER = 8'h24;
   localparam logic [7:0] DWCR_OFF_RSVD_A = 8'h28;
   localparam logic [7:0] DWCR_OFF_SUBSYS = 8'h2c;
   localparam logic [7:0] DWCR_OFF_RSVD_B = 8'h30;
   localparam logic [7:0] DWCR_OFF_CAP = 8'h34;
   localparam logic [7:0] DWCR_OFF_ROM = 8'h38;
   // Setup, translation and status registers, our own offsets
   localparam logic [7:0] DWCR_OFF_SETUP_LO = 8'h40;
   localparam logic [7:0] DWCR_OFF_SETUP_HI = 8'h44;
   localparam logic [7:0] DWCR_OFF_XLAT = 8'h48;
   localparam logic [7:0] DWCR_OFF_STATUS = 8'h4c;
   // ==========================================
   // Field positions and values
   localparam int DWCR_ENABLE_BIT = 31;
   localparam int DWCR_TYPE_LSB = 1;
   localparam int DWCR_PREF_BIT = 3;
   localparam int DWCR_BASE_LSB = 12;
   localparam logic [1:0] DWCR_TYPE_32 = 2'h0;
   localparam logic [1:0] DWCR_TYPE_64 = 2'h1;
   localparam logic [7:0] DWCR_CAP_PTR = 8'h80;
   localparam logic [31:0] DWCR_ROM_VALUE = 32'h0000_0000;
   localparam logic [31:0] DWCR_RESET_ZERO = 32'h0000_0000;
   // Setup low: [31] enable, [31:12] size mask, [3] prefetch, [2:1] type
   localparam logic [31:0] DWCR_SETUP_LO_RST = 32'h0000_0000;
   localparam logic [31:0] DWCR_SETUP_HI_RST = 32'h0000_0000;
   localparam logic [31:0] DWCR_LOW_RO_MASK = 32'h0000_0fff;
endpackage : dwcr_pkg

//--- src/dwcr_wb_slave.sv
/*
 Classic Wishbone slave front end: registers one access per request.
 Assumes a master that holds the request until ack.
*/
`timescale 1ns/10ps
module dwcr_wb_slave
   import dwcr_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic acc_wr,
   output logic acc_rd
);
   typedef struct packed {
      logic ack;
   } dwcr_slv_t;
   dwcr_slv_t st_q, st_d;

   // ==========================================
   // One-cycle ack, dropped in the following cycle
   always_comb
   begin
      st_d = st_q;
      st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign wb_ack_o = st_q.ack;
   // Write lands on the edge where the master samples ack high
   assign acc_wr = wb_cyc_i && wb_stb_i && st_q.ack;
   assign acc_rd = st_d.ack;
endmodule : dwcr_wb_slave

//--- src/dwcr_xlate.sv
/*
 Window hit check and address translation for the downstream window.
 Assumes base, mask and type come straight from the register block.
*/
`timescale 1ns/10ps
module dwcr_xlate
   import dwcr_pkg::*;
(
   input wire logic [63:0] in_addr,
   input wire logic [63:0] base,
   input wire logic [63:0] mask,
   input wire logic is64,
   input wire logic [31:0] xlat_base,
   input wire logic en,
   output logic hit,
   output logic [63:0] out_addr
);
   always_comb
   begin
      hit = en && ((in_addr & mask) == (base & mask));
      if (is64)
         out_addr = in_addr;
      else
         out_addr = {32'h0000_0000, (xlat_base & mask[31:0]) | (in_addr[31:0] & ~mask[31:0])};
   end
endmodule : dwcr_xlate

//--- verification/dwcr_top_tb_top.sv
/*
 Self-checking bench for dwcr_top: a register model and window checks.
 Assumes one 100 MHz clock and the single-cycle Wishbone timing of the block.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module dwcr_top_tb_top import dwcr_pkg::*;;
   // Arbitrary identity values
   localparam logic [15:0] VID = 16'h0abc;
   localparam logic [15:0] DID = 16'h0def;
   logic clock = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, hit;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dat_o, m_slo = 32'h0, m_shi = 32'h0;
   logic [31:0] m_base = 32'h0, m_up = 32'h0, m_xl = 32'h0;
   logic [63:0] req = 64'h0, fwd;
   logic [31:0] setups [3] = '{32'hff000003, 32'hfff00009, 32'hfffff00b};
   int miscompares = 0, samples_checked = 0;

   dwcr_top #(.SUBSYS_VENDOR(VID), .SUBSYS_DEVICE(DID)) i_dut (.clock(clock), .nrst(nrst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .req_addr(req), .win_hit(hit),
      .fwd_addr(fwd));

   initial forever #5 clock = ~clock;

   // ==========================================
   // Bus tasks and model
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      @(posedge clock);
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      if (n == 20)
      begin
         miscompares++;
         $display("wrong value at %0t: no ack", $time);
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic [31:0] bm, m;
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      xfer(1'b1, a, d, s);
      m = 32'h0;
      case (a)
         8'h20: m = m_slo[31] ? bm & m_slo & 32'hfffff000 : 32'h0;
         8'h24: m = m_shi[31] ? bm & m_shi : 32'h0;
         8'h40: m = bm & 32'hffff_f00e;
         8'h44: m = bm;
         8'h48: m = bm & 32'hfffff000;
         default: m = 32'h0;
      endcase
      case (a)
         8'h20: m_base = (m_base & ~m) | (d & m);
         8'h24: m_up = (m_up & ~m) | (d & m);
         8'h40: m_slo = (m_slo & ~m) | (d & m);
         8'h44: m_shi = (m_shi & ~m) | (d & m);
         8'h48: m_xl = (m_xl & ~m) | (d & m);
         default: ;
      endcase
   endtask : wr

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h20: return m_slo[31] ? (m_base & m_slo & 32'hfffff000) | (m_slo & 32'he) : 32'h0;
         8'h24: return m_shi[31] ? m_up & m_shi : 32'h0;
         8'h2c: return {DID, VID};
         8'h34: return 32'h80;
         8'h40: return m_slo;
         8'h44: return m_shi;
         8'h48: return m_xl;
         default: return 32'h0;
      endcase
   endfunction : exp_rd

   task rd_chk(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, 4'hf);
      `CHK(rdat, exp_rd(a))
   endtask : rd_chk

   task win(input logic [63:0] a, input logic h, input logic [63:0] f);
      @(posedge clock);
      req <= a;
      @(posedge clock);
      @(posedge clock);
      `CHK(hit, h)
      `CHK(fwd, f)
   endtask : win

   task give_verdict;
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // ==========================================
   // Tests
   initial
   begin
      void'($urandom(5509));
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      for (int a = 'h20; a <= 'h4c; a += 4) rd_chk(8'(a));
      rd_chk(8'h50);
      $display("test reset values done");
      for (int a = 'h28; a <= 'h38; a += 4)
      begin
         wr(8'(a), $urandom);
         rd_chk(8'(a));
      end
      wr(8'h20, $urandom);
      rd_chk(8'h20);
      $display("test read-only words done");
      // Masks only gain ones, so no stale base bits sit outside a mask
      wr(8'h44, 32'hffffffff);
      foreach (setups[i])
      begin
         wr(8'h40, setups[i]);
         rd_chk(8'h40);
         wr(8'h20, $urandom);
         rd_chk(8'h20);
         wr(8'h20, $urandom, 4'h4);
         rd_chk(8'h20);
      end
      $display("test base sizing done");
      wr(8'h20, 32'h0);
      wr(8'h40, 32'hfff00001);
      wr(8'h20, 32'h12345678);
      wr(8'h48, $urandom);
      rd_chk(8'h48);
      win({32'h0, 32'h123abcde}, 1'b1, {32'h0, (m_xl & 32'hfff00000) | 32'h000abcde});
      win({32'h0, 32'h124abcde}, 1'b0, {32'h0, (m_xl & 32'hfff00000) | 32'h000abcde});
      wr(8'h40, 32'hfff00003);
      wr(8'h24, $urandom);
      rd_chk(8'h24);
      win({m_up, 32'h123abcde}, 1'b1, {m_up, 32'h123abcde});
      win({~m_up, 32'h123abcde}, 1'b0, {~m_up, 32'h123abcde});
      $display("test window decode done");
      wr(8'h44, 32'h7fffffff);
      rd_chk(8'h24);
      wr(8'h40, 32'h7ff00001);
      rd_chk(8'h20);
      win({32'h0, 32'h123abcde}, 1'b0, {32'h0, (m_xl & 32'h7ff00000) | 32'h000abcde});
      $display("test disable done");
      give_verdict();
   end

   initial
   begin
      #100000;
      miscompares++;
      $display("wrong value at %0t: timeout", $time);
      give_verdict();
   end
endmodule : dwcr_top_tb_top
